// ---- verilog/fns_map.svh ----
// offsets, field positions, reset values and timing of the fieldbus node setup block
// Functional notes
// - sample decimal address switches, 0..63, default 63
// - changed address is written to nonvolatile store
// - switch value above 63 keeps previous address
// - high digit program position: address from network
// - rate switch 1/2/5 gives 125/250/500k, default 500k
// - rate program position: rate from network
// - after clean start idle, fallback value sent
// - live measurement only in active transfer state
// - start or polled io in idle enters active
// - module led: selftest alternate, green, red, blink red
// - network led: off, blink green, solid green
// - network led: timeout blinks red, comm error red
// - profibus hex address 00..7D, not bus changeable
// - above 7D start at 126, master assigns, lock
// - store bus address and lock, erase below 126
// - ethercat reads three hex switches as identification
// - ethercat id is hundreds_hex_digit_switch*0x100 + x10*0x10 + x1
`ifndef FNS_MAP_SVH
`define FNS_MAP_SVH

`define FNS_REG_STATUS 8'h00
`define FNS_REG_EXPL_ID 8'h04
`define FNS_REG_FALLBACK 8'h08
`define FNS_REG_IRQ_STAT 8'h0C
`define FNS_REG_IRQ_MASK 8'h10

`define FNS_STAT_RATE_LSB 8
`define FNS_STAT_VAR_LSB 10
`define FNS_STAT_ADDR_LSB 16

`define FNS_DNET_ADDR_MAX 8'h3F
`define FNS_DNET_ADDR_RST 7'h3F
`define FNS_PBUS_ADDR_MAX 8'h7D
`define FNS_PBUS_ADDR_START 7'h7E
`define FNS_SW_PROG 4'hF
`define FNS_RATE_SW_125 4'h1
`define FNS_RATE_SW_250 4'h2
`define FNS_FALLBACK_RST 16'h0000
`define FNS_CAP_WAIT 2'h2

`define FNS_VAR_DNET 2'h0
`define FNS_VAR_PBUS 2'h1
`define FNS_VAR_ECAT 2'h2

`define FNS_CLK_PERIOD_NS 5
`define FNS_BLINK_MS 500

`endif

// ---- verilog/fns_pkg.sv ----
// types of the fieldbus node setup block
package fns_pkg;

    typedef enum logic [1:0] {RUN_SELFTEST, RUN_IDLE, RUN_ACTIVE, RUN_FAULT} fns_run_t;

    typedef enum logic [1:0] {RATE_125K, RATE_250K, RATE_500K} fns_rate_t;

    typedef struct packed {
        logic green;
        logic red;
    } fns_led_t;

    typedef struct packed {
        logic [3:0] hi_s1, hi_s2, lo_s1, lo_s2, rt_s1, rt_s2;
        logic [11:0] hx_s1, hx_s2;
        logic [1:0] var_s1, var_s2;
        logic [1:0] cap_cnt;
        logic captured;
        logic [1:0] variant;
        logic addr_prog;
        logic rate_prog;
        logic pb_assign;
        logic addr_lock;
        logic [6:0] node_addr;
        fns_rate_t rate;
        logic [11:0] expl_id;
        logic nv_wr;
        logic [6:0] nv_wr_addr;
        logic nv_wr_lock;
        logic nv_erase;
        fns_run_t run;
        logic [15:0] tx_value;
        logic tx_live;
        logic [15:0] fallback;
        logic [26:0] blink_cnt;
        logic blink_ph;
        fns_led_t mod_led;
        fns_led_t net_led;
        logic [5:0] irq_stat;
        logic [5:0] irq_mask;
        logic irq;
        logic awready, wready, aw_got, w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready, rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fns_state_t;

endpackage

// ---- verilog/fns_node_ctrl.sv ----
// fieldbus node setup and status block with axi4-lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`include "fns_map.svh"

module fns_node_ctrl import fns_pkg::*; #(
    parameter int BLINK_CYC = `FNS_BLINK_MS * 1000000 / `FNS_CLK_PERIOD_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] address_high_digit_switch,
    input wire logic [3:0] address_low_digit_switch,
    input wire logic [3:0] rate_switch,
    input wire logic [3:0] hundreds_hex_digit_switch,
    input wire logic [3:0] tens_hex_digit_switch,
    input wire logic [3:0] units_hex_digit_switch,
    input wire logic [1:0] bus_variant,
    input wire logic [6:0] nv_rd_addr,
    input wire logic net_addr_valid,
    input wire logic [6:0] net_addr,
    input wire logic net_addr_lock,
    input wire logic net_rate_valid,
    input wire logic [1:0] net_rate,
    input wire logic selftest_done,
    input wire logic fatal_error,
    input wire logic bus_power_ok,
    input wire logic start_cmd,
    input wire logic poll_start,
    input wire logic stop_cmd,
    input wire logic master_connected,
    input wire logic conn_timeout,
    input wire logic comm_error,
    input wire logic [15:0] meas_value,
    output logic [6:0] node_address,
    output fns_rate_t data_rate,
    output logic [11:0] explicit_device_id,
    output logic nv_wr,
    output logic [6:0] nv_wr_addr,
    output logic nv_wr_lock,
    output logic nv_erase,
    output logic [15:0] tx_value,
    output logic tx_live,
    output fns_led_t module_status_led,
    output fns_led_t network_status_led,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    fns_state_t st_r, st_nxt;
    logic cap_now;
    logic [7:0] dec_val;
    logic [7:0] hex_val;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign cap_now = !st_r.captured && (st_r.cap_cnt == `FNS_CAP_WAIT);
    assign dec_val = 8'({4'h0, st_r.hi_s2} * 8'd10) + {4'h0, st_r.lo_s2};
    assign hex_val = {st_r.hi_s2, st_r.lo_s2};

    always_comb begin
        logic [5:0] ev;
        logic [5:0] clr;
        logic [31:0] mw;
        ev = '0;
        clr = '0;
        mw = '0;
        st_nxt = st_r;
        st_nxt.nv_wr = 1'b0;
        st_nxt.nv_erase = 1'b0;
        // pin synchronisers
        st_nxt.hi_s1 = address_high_digit_switch;
        st_nxt.hi_s2 = st_r.hi_s1;
        st_nxt.lo_s1 = address_low_digit_switch;
        st_nxt.lo_s2 = st_r.lo_s1;
        st_nxt.rt_s1 = rate_switch;
        st_nxt.rt_s2 = st_r.rt_s1;
        st_nxt.hx_s1 = {hundreds_hex_digit_switch, tens_hex_digit_switch, units_hex_digit_switch};
        st_nxt.hx_s2 = st_r.hx_s1;
        st_nxt.var_s1 = bus_variant;
        st_nxt.var_s2 = st_r.var_s1;
        // one-time switch capture
        if (!st_r.captured && !cap_now) begin
            st_nxt.cap_cnt = st_r.cap_cnt + 2'd1;
        end
        if (cap_now) begin
            st_nxt.captured = 1'b1;
            st_nxt.variant = st_r.var_s2;
            st_nxt.expl_id = st_r.hx_s2;
            st_nxt.rate_prog = (st_r.rt_s2 == `FNS_SW_PROG);
            if (st_r.rt_s2 == `FNS_RATE_SW_125) begin
                st_nxt.rate = RATE_125K;
            end else if (st_r.rt_s2 == `FNS_RATE_SW_250) begin
                st_nxt.rate = RATE_250K;
            end else begin
                st_nxt.rate = RATE_500K;
            end
            if (st_r.var_s2 == `FNS_VAR_DNET) begin
                if (st_r.hi_s2 == `FNS_SW_PROG) begin
                    st_nxt.addr_prog = 1'b1;
                    st_nxt.node_addr = nv_rd_addr;
                end else if (dec_val > `FNS_DNET_ADDR_MAX) begin
                    st_nxt.node_addr = nv_rd_addr;
                end else begin
                    st_nxt.node_addr = dec_val[6:0];
                    if (dec_val[6:0] != nv_rd_addr) begin
                        st_nxt.nv_wr = 1'b1;
                        st_nxt.nv_wr_addr = dec_val[6:0];
                    end
                end
            end else if (st_r.var_s2 == `FNS_VAR_PBUS) begin
                if (hex_val <= `FNS_PBUS_ADDR_MAX) begin
                    st_nxt.node_addr = hex_val[6:0];
                    st_nxt.nv_erase = 1'b1;
                end else begin
                    st_nxt.node_addr = `FNS_PBUS_ADDR_START;
                    st_nxt.pb_assign = 1'b1;
                end
            end
            ev[0] = 1'b1;
        end
        // address and rate written over the network
        if (st_r.captured && net_addr_valid) begin
            if (st_r.variant == `FNS_VAR_DNET && st_r.addr_prog &&
                {1'b0, net_addr} <= `FNS_DNET_ADDR_MAX) begin
                st_nxt.node_addr = net_addr;
                st_nxt.nv_wr = 1'b1;
                st_nxt.nv_wr_addr = net_addr;
                ev[1] = 1'b1;
            end else if (st_r.variant == `FNS_VAR_PBUS && st_r.pb_assign &&
                         !st_r.addr_lock) begin
                st_nxt.node_addr = net_addr;
                st_nxt.addr_lock = net_addr_lock;
                st_nxt.nv_wr = 1'b1;
                st_nxt.nv_wr_addr = net_addr;
                st_nxt.nv_wr_lock = net_addr_lock;
                ev[1] = 1'b1;
            end
        end
        if (st_r.captured && st_r.rate_prog && net_rate_valid && net_rate != 2'h3) begin
            st_nxt.rate = fns_rate_t'(net_rate);
        end
        // run state
        unique case (st_r.run)
            RUN_SELFTEST: begin
                if (selftest_done && st_r.captured && !fatal_error) begin
                    st_nxt.run = RUN_IDLE;
                end
            end
            RUN_IDLE: begin
                if (start_cmd || poll_start) begin
                    st_nxt.run = RUN_ACTIVE;
                    ev[2] = 1'b1;
                end
            end
            RUN_ACTIVE: begin
                if (stop_cmd) begin
                    st_nxt.run = RUN_IDLE;
                end
            end
            RUN_FAULT: begin
            end
        endcase
        if (fatal_error && st_r.run != RUN_FAULT) begin
            st_nxt.run = RUN_FAULT;
            ev[3] = 1'b1;
        end
        st_nxt.tx_live = (st_nxt.run == RUN_ACTIVE);
        st_nxt.tx_value = st_nxt.tx_live ? meas_value : st_r.fallback;
        // blink divider
        if (st_r.blink_cnt == 27'(BLINK_CYC - 1)) begin
            st_nxt.blink_cnt = '0;
            st_nxt.blink_ph = !st_r.blink_ph;
        end else begin
            st_nxt.blink_cnt = st_r.blink_cnt + 27'd1;
        end
        // module status led
        if (st_nxt.run == RUN_SELFTEST) begin
            st_nxt.mod_led = '{green: st_r.blink_ph, red: !st_r.blink_ph};
        end else if (st_nxt.run == RUN_FAULT) begin
            st_nxt.mod_led = '{green: 1'b0, red: 1'b1};
        end else if (!bus_power_ok) begin
            st_nxt.mod_led = '{green: 1'b0, red: st_r.blink_ph};
        end else begin
            st_nxt.mod_led = '{green: 1'b1, red: 1'b0};
        end
        // network status led
        if (st_nxt.run == RUN_SELFTEST) begin
            st_nxt.net_led = '{green: 1'b0, red: 1'b0};
        end else if (comm_error) begin
            st_nxt.net_led = '{green: 1'b0, red: 1'b1};
        end else if (conn_timeout) begin
            st_nxt.net_led = '{green: 1'b0, red: st_r.blink_ph};
        end else if (master_connected) begin
            st_nxt.net_led = '{green: 1'b1, red: 1'b0};
        end else begin
            st_nxt.net_led = '{green: st_r.blink_ph, red: 1'b0};
        end
        ev[4] = conn_timeout;
        ev[5] = comm_error;
        // axi write channel
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_nxt.aw_got && st_nxt.w_got && !st_nxt.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = 2'h0;
            unique case ({st_nxt.awaddr[7:2], 2'h0})
                `FNS_REG_FALLBACK: begin
                    mw = merge_bytes({16'h0000, st_r.fallback}, st_nxt.wdata, st_nxt.wstrb);
                    st_nxt.fallback = mw[15:0];
                end
                `FNS_REG_IRQ_STAT: begin
                    clr = st_nxt.wstrb[0] ? st_nxt.wdata[5:0] : 6'h00;
                end
                `FNS_REG_IRQ_MASK: begin
                    mw = merge_bytes({26'h0, st_r.irq_mask}, st_nxt.wdata, st_nxt.wstrb);
                    st_nxt.irq_mask = mw[5:0];
                end
                `FNS_REG_STATUS, `FNS_REG_EXPL_ID: begin
                end
                default: begin
                    st_nxt.bresp = 2'h2;
                end
            endcase
        end
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
        // sticky events, set beats clear
        st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
        // axi read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = 2'h0;
            unique case ({s_axi_araddr[7:2], 2'h0})
                `FNS_REG_STATUS: begin
                    st_nxt.rdata = '0;
                    st_nxt.rdata[1:0] = st_r.run;
                    st_nxt.rdata[7:2] = {st_r.captured, st_r.addr_lock, st_r.pb_assign,
                                         st_r.rate_prog, st_r.addr_prog, st_r.tx_live};
                    st_nxt.rdata[`FNS_STAT_RATE_LSB +: 2] = st_r.rate;
                    st_nxt.rdata[`FNS_STAT_VAR_LSB +: 2] = st_r.variant;
                    st_nxt.rdata[`FNS_STAT_ADDR_LSB +: 7] = st_r.node_addr;
                end
                `FNS_REG_EXPL_ID: st_nxt.rdata = {20'h00000, st_r.expl_id};
                `FNS_REG_FALLBACK: st_nxt.rdata = {16'h0000, st_r.fallback};
                `FNS_REG_IRQ_STAT: st_nxt.rdata = {26'h0, st_r.irq_stat};
                `FNS_REG_IRQ_MASK: st_nxt.rdata = {26'h0, st_r.irq_mask};
                default: begin
                    st_nxt.rdata = '0;
                    st_nxt.rresp = 2'h2;
                end
            endcase
        end
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.node_addr <= `FNS_DNET_ADDR_RST;
            st_r.rate <= RATE_500K;
            st_r.run <= RUN_SELFTEST;
            st_r.fallback <= `FNS_FALLBACK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign node_address = st_r.node_addr;
    assign data_rate = st_r.rate;
    assign explicit_device_id = st_r.expl_id;
    assign nv_wr = st_r.nv_wr;
    assign nv_wr_addr = st_r.nv_wr_addr;
    assign nv_wr_lock = st_r.nv_wr_lock;
    assign nv_erase = st_r.nv_erase;
    assign tx_value = st_r.tx_value;
    assign tx_live = st_r.tx_live;
    assign module_status_led = st_r.mod_led;
    assign network_status_led = st_r.net_led;
    assign irq = st_r.irq;
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rvalid = st_r.rvalid;

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_dnet_cap;
        cap_now && st_r.var_s2 == `FNS_VAR_DNET && st_r.hi_s2 != `FNS_SW_PROG;
    endsequence

    sequence s_start_req;
        st_r.run == RUN_IDLE && (start_cmd || poll_start) && !fatal_error;
    endsequence

    property p_addr_range;
        s_dnet_cap ##0 (dec_val <= `FNS_DNET_ADDR_MAX) |=> node_address == $past(dec_val[6:0]);
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("switch address not taken");

    property p_nv_write;
        s_dnet_cap ##0 (dec_val <= `FNS_DNET_ADDR_MAX && dec_val[6:0] != nv_rd_addr)
            |=> nv_wr && nv_wr_addr == node_address ##1 !nv_wr;
    endproperty
    a_nv_write: assert property (p_nv_write) else $error("changed address not stored");

    property p_keep_prev;
        s_dnet_cap ##0 (dec_val > `FNS_DNET_ADDR_MAX) |=> !nv_wr && node_address == $past(nv_rd_addr);
    endproperty
    a_keep_prev: assert property (p_keep_prev) else $error("out of range address used");

    property p_rate;
        cap_now && st_r.rt_s2 == `FNS_RATE_SW_250 |=> data_rate == RATE_250K;
    endproperty
    a_rate: assert property (p_rate) else $error("rate switch decode wrong");

    property p_start;
        s_start_req |=> st_r.run == RUN_ACTIVE && tx_live && tx_value == $past(meas_value);
    endproperty
    a_start: assert property (p_start) else $error("start did not enter active");

    property p_fallback;
        st_r.run == RUN_IDLE && !start_cmd && !poll_start |=> !tx_live && tx_value == $past(st_r.fallback);
    endproperty
    a_fallback: assert property (p_fallback) else $error("live value sent while idle");

    property p_net_off;
        st_r.run == RUN_SELFTEST && !selftest_done ##1 st_r.run == RUN_SELFTEST
            |-> network_status_led == '{green: 1'b0, red: 1'b0};
    endproperty
    a_net_off: assert property (p_net_off) else $error("network led lit in selftest");

    property p_comm_err;
        st_r.run != RUN_SELFTEST && comm_error && !fatal_error
            |=> network_status_led.red && !network_status_led.green;
    endproperty
    a_comm_err: assert property (p_comm_err) else $error("comm error not solid red");

    property p_pb_fixed;
        st_r.captured && st_r.variant == `FNS_VAR_PBUS && !st_r.pb_assign |=> $stable(node_address);
    endproperty
    a_pb_fixed: assert property (p_pb_fixed) else $error("fixed address changed");

    property p_expl;
        cap_now && st_r.var_s2 == `FNS_VAR_ECAT |=> explicit_device_id == $past(st_r.hx_s2) ##1
            $stable(explicit_device_id)[*3];
    endproperty
    a_expl: assert property (p_expl) else $error("explicit id not captured");

endmodule

// ---- sim/fns_master_model.sv ----
// fieldbus master model driving the control pulses of the node
module fns_master_model (
    input wire logic aclk,
    output logic start_cmd,
    output logic poll_start,
    output logic stop_cmd,
    output logic net_addr_valid,
    output logic [6:0] net_addr,
    output logic net_addr_lock,
    output logic net_rate_valid,
    output logic [1:0] net_rate
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {start_cmd, poll_start, stop_cmd, net_addr_valid, net_addr_lock, net_rate_valid} = '0;
        net_addr = 7'h55;
        net_rate = 2'h3;
    end
    // k: 0 start, 1 poll, 2 stop, 3 address, 4 rate; gap idle cycles first
    task send(input int k, input logic [6:0] v, input logic lk, input int gap);
        repeat (gap) @(posedge aclk);
        @(posedge aclk);
        case (k)
            0: start_cmd <= 1'b1;
            1: poll_start <= 1'b1;
            2: stop_cmd <= 1'b1;
            3: begin
                net_addr_valid <= 1'b1;
                net_addr <= v;
                net_addr_lock <= lk;
            end
            default: begin
                net_rate_valid <= 1'b1;
                net_rate <= v[1:0];
            end
        endcase
        @(posedge aclk);
        {start_cmd, poll_start, stop_cmd, net_addr_valid, net_rate_valid} <= '0;
        net_addr <= ~v;
        net_rate <= ~v[1:0];
    endtask
endmodule

// ---- sim/fns_node_ctrl_test.sv ----
// self-checking bench of the fieldbus node setup block
module fns_node_ctrl_test import fns_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, net_addr_valid, net_addr_lock, net_rate_valid, start_cmd, poll_start;
    logic stop_cmd, selftest_done, fatal_error, bus_power_ok, master_connected, conn_timeout;
    logic comm_error, nv_wr, nv_wr_lock, nv_erase, tx_live, irq, wr_seen, er_seen, wr_l;
    logic [3:0] address_high_digit_switch, address_low_digit_switch, rate_switch, s_axi_wstrb;
    logic [3:0] hundreds_hex_digit_switch, tens_hex_digit_switch, units_hex_digit_switch;
    logic [1:0] bus_variant, net_rate, s_axi_bresp, s_axi_rresp, rs;
    logic [6:0] nv_rd_addr, net_addr, node_address, nv_wr_addr, wr_a;
    logic [11:0] explicit_device_id;
    logic [15:0] meas_value, tx_value;
    fns_rate_t data_rate;
    fns_led_t module_status_led, network_status_led;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_errors, n_checks;

    fns_node_ctrl #(.BLINK_CYC(4)) dut (.*);
    fns_master_model master (.*);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_seen <= 1'b0;
            er_seen <= 1'b0;
        end
        if (nv_wr === 1'b1) begin
            wr_seen <= 1'b1;
            wr_a <= nv_wr_addr;
            wr_l <= nv_wr_lock;
        end
        if (nv_erase === 1'b1) er_seen <= 1'b1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function int cat(int c);
        return c == 0 ? 0 : (c == 12 ? 2 : 1);
    endfunction
    // led pattern over 12 cycles: 0 never, 1 blinking, 2 steady
    task led(input logic s, input int eg, input int er);
        int g, r;
        fns_led_t l;
        g = 0;
        r = 0;
        repeat (3) @(posedge aclk);
        repeat (12) begin
            @(posedge aclk);
            l = s ? network_status_led : module_status_led;
            g += int'(l.green === 1'b1);
            r += int'(l.red === 1'b1);
            chk(32'($isunknown(l)), 32'h0);
        end
        chk(32'(cat(g)), 32'(eg));
        chk(32'(cat(r)), 32'(er));
    endtask
    task rst(input logic [3:0] h, input logic [3:0] l, input logic [3:0] r, input logic [1:0] v);
        @(posedge aclk);
        aresetn <= 1'b0;
        address_high_digit_switch <= h;
        address_low_digit_switch <= l;
        rate_switch <= r;
        bus_variant <= v;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #60000;
        n_errors++;
        give_verdict();
    end
    initial begin
        n_errors = 0;
        n_checks = 0;
        aresetn = 1'b0;
        {selftest_done, fatal_error, master_connected, conn_timeout, comm_error} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {hundreds_hex_digit_switch, tens_hex_digit_switch, units_hex_digit_switch} = '0;
        {address_high_digit_switch, address_low_digit_switch, rate_switch, bus_variant} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        bus_power_ok = 1'b1;
        meas_value = 16'hBEEF;
        nv_rd_addr = 7'h05;
        rst(4'h4, 4'h2, 4'h1, 2'h0);
        chk(32'({node_address, data_rate}), 32'({7'h2A, RATE_125K}));
        chk(32'({wr_seen, wr_a}), 32'({1'b1, 7'h2A}));
        led(0, 1, 1);
        led(1, 0, 0);
        selftest_done <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'({tx_live, tx_value}), 32'h0);
        axi_wr(8'h08, 32'h1234, rs);
        axi_rd(8'h08, rdat, rs);
        chk(rdat, 32'h1234);
        chk(32'(tx_value), 32'h1234);
        axi_rd(8'h40, rdat, rs);
        chk(32'(rs), 32'h2);
        axi_wr(8'h40, 32'h0, rs);
        chk(32'(rs), 32'h2);
        led(0, 2, 0);
        led(1, 1, 0);
        master_connected <= 1'b1;
        led(1, 2, 0);
        axi_wr(8'h10, 32'h4, rs);
        chk(32'(irq), 32'h0);
        master.send(0, 7'h0, 1'b0, 0);
        repeat (2) @(posedge aclk);
        chk(32'({tx_live, tx_value}), 32'h1BEEF);
        chk(32'(irq), 32'h1);
        axi_rd(8'h0C, rdat, rs);
        chk(rdat & 32'h4, 32'h4);
        axi_wr(8'h0C, 32'h4, rs);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        master.send(2, 7'h0, 1'b0, 3);
        repeat (2) @(posedge aclk);
        chk(32'({tx_live, tx_value}), 32'h01234);
        master.send(1, 7'h0, 1'b0, 0);
        repeat (2) @(posedge aclk);
        chk(32'(tx_live), 32'h1);
        address_high_digit_switch <= 4'h1;
        rate_switch <= 4'h2;
        repeat (6) @(posedge aclk);
        chk(32'({node_address, data_rate}), 32'({7'h2A, RATE_125K}));
        conn_timeout <= 1'b1;
        led(1, 0, 1);
        comm_error <= 1'b1;
        led(1, 0, 2);
        bus_power_ok <= 1'b0;
        led(0, 0, 1);
        bus_power_ok <= 1'b1;
        fatal_error <= 1'b1;
        led(0, 0, 2);
        chk(32'(tx_live), 32'h0);
        {fatal_error, conn_timeout, comm_error} <= 3'h0;
        $display("test 1 done");
        nv_rd_addr <= 7'h0C;
        rst(4'h7, 4'h0, 4'h2, 2'h0);
        chk(32'({wr_seen, node_address, data_rate}), 32'({1'b0, 7'h0C, RATE_250K}));
        rst(4'hF, 4'h0, 4'hF, 2'h0);
        master.send(3, 7'h21, 1'b0, 0);
        master.send(4, 7'h0, 1'b0, 0);
        repeat (2) @(posedge aclk);
        chk(32'({node_address, data_rate}), 32'({7'h21, RATE_125K}));
        rst(4'h1, 4'h0, 4'h5, 2'h0);
        master.send(3, 7'h21, 1'b0, 0);
        master.send(4, 7'h1, 1'b0, 0);
        repeat (2) @(posedge aclk);
        chk(32'({node_address, data_rate}), 32'({7'h0A, RATE_500K}));
        $display("test 2 done");
        rst(4'h7, 4'hD, 4'h5, 2'h1);
        chk(32'({er_seen, node_address}), 32'({1'b1, 7'h7D}));
        master.send(3, 7'h14, 1'b0, 0);
        repeat (2) @(posedge aclk);
        chk(32'(node_address), 32'h7D);
        rst(4'h8, 4'h0, 4'h5, 2'h1);
        chk(32'(node_address), 32'h7E);
        master.send(3, 7'h14, 1'b1, 0);
        repeat (2) @(posedge aclk);
        chk(32'({node_address, wr_seen, wr_a, wr_l}), 32'({7'h14, 1'b1, 7'h14, 1'b1}));
        master.send(3, 7'h1E, 1'b0, 2);
        repeat (2) @(posedge aclk);
        chk(32'(node_address), 32'h14);
        $display("test 3 done");
        hundreds_hex_digit_switch <= 4'h3;
        tens_hex_digit_switch <= 4'hA;
        units_hex_digit_switch <= 4'h5;
        rst(4'h0, 4'h0, 4'h5, 2'h2);
        chk(32'(explicit_device_id), 32'h3A5);
        axi_rd(8'h04, rdat, rs);
        chk(rdat, 32'h3A5);
        axi_rd(8'h00, rdat, rs);
        chk(rdat, 32'h003F0A81);
        $display("test 4 done");
        give_verdict();
    end
endmodule
